/* fpb_pkg.sv */
// Shared constants and types for the parallel flash bus host controller.
// Assumes a single 10 MHz core clock and an asynchronous flash part on the far side of the pins.
//
// Summary of operation
// RULE_01 - A read drives chip select and output enable low while write enable stays high for the whole cycle.
// RULE_02 - The flash drives its data pins only while output enable is low, and chip select selects and powers it; the model drives inverted lastQ otherwise.
// RULE_03 - A write drives write enable and chip select low while output enable is held high.
// RULE_04 - After power-up or hardware reset the flash sits in array read, so no alteration happens in the transition.
// RULE_05 - In array read the flash returns stored bytes for plain reads with no command issued first.
// RULE_06 - A standard read with a valid address returns the byte stored at that address.
// RULE_07 - The flash leaves array read only when a write changes its command register, never because of a read.
// RULE_08 - The command register has no address of its own and is reached by the bus cycle type.
// RULE_09 - Each write cycle latches command, address and data, and those latches steer the flash state machine.
// RULE_10 - In unlock bypass a byte program takes two write cycles instead of four, and the host issues the short form.
// RULE_11 - An erase can target one sector, several sectors, or the whole array.
// RULE_12 - A sector address is exactly the upper address bits that pick one sector, and the host supplies them.
// RULE_13 - After the autoselect sequence, reads return identification codes from a register apart from the array.
// RULE_14 - The host detects program or erase completion by reading status and checking bit 7 and toggle bit 6.
// RULE_15 - The flash ignores writes while output enable is low, chip select is high, or write enable is high.
// RULE_16 - The flash has a 19-bit byte address and an 8-bit data bus that floats whenever no read is driven; the model drives inverted lastQ instead.

package fpb_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_ACC_NS      = 120;
  localparam int T_WE_LOW_NS   = 50;
  localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_RAW_CYC    = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_CYC        = (WE_RAW_CYC < 1) ? 1 : WE_RAW_CYC;
  localparam int SYNC_CYC      = 3;
  // Output enable stays low until the synchroniser output holds the settled byte.
  localparam int READ_WAIT_CYC = ACC_CYC + SYNC_CYC + 1;
  localparam int CNT_W         = 3;

  // ****************************************************************
  // Bus layout
  // ****************************************************************
  localparam int ADDR_W     = 19;
  localparam int DATA_W     = 8;
  localparam int SECTOR_LSB = 16;
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [3:0] {
    OP_READ         = 4'h0,
    OP_WRITE        = 4'h1,
    OP_RESET        = 4'h2,
    OP_PROGRAM      = 4'h3,
    OP_BYP_ENTER    = 4'h4,
    OP_BYP_PROGRAM  = 4'h5,
    OP_BYP_EXIT     = 4'h6,
    OP_CHIP_ERASE   = 4'h7,
    OP_SECTOR_ERASE = 4'h8,
    OP_SECTOR_ADD   = 4'h9,
    OP_AUTOSELECT   = 4'ha,
    OP_POLL         = 4'hb
  } fpb_op_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_SETUP   = 3'h1,
    ST_STROBE  = 3'h3,
    ST_RECOVER = 3'h2,
    ST_DONE    = 3'h6
  } fpb_state_t;

  typedef struct packed {
    logic              isRead;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpb_step_t;

endpackage

/* fpb_sync_if.sv */
// Carries the raw flash data pins into the synchroniser and the settled byte back out.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps

interface fpb_sync_if;
  logic [fpb_pkg::DATA_W-1:0] rawIn;
  logic [fpb_pkg::DATA_W-1:0] synced;

  modport src  (output rawIn, input synced);
  modport sink (input rawIn, output synced);
endinterface

/* fpb_pin_sync.sv */
// Three-stage synchroniser for the flash data pins.
// Assumes the pins change without regard to the core clock.
`timescale 1ns/100ps

module fpb_pin_sync (
  input wire logic core_clk,
  input wire logic rst,
  fpb_sync_if.sink link
);
  import fpb_pkg::*;

  logic [DATA_W-1:0] s1_r;
  logic [DATA_W-1:0] s2_r;
  logic [DATA_W-1:0] s3_r;
  logic [DATA_W-1:0] out_r;
  logic [DATA_W-1:0] out_nxt;

  // A new byte is taken only once the second and third stages agree, which filters a metastable first stage.
  always_comb begin
    out_nxt = out_r;
    if (s2_r == s3_r) begin
      out_nxt = s3_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r  <= 8'h00;
      s2_r  <= 8'h00;
      s3_r  <= 8'h00;
      out_r <= 8'h00;
    end else begin
      s1_r  <= link.rawIn;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign link.synced = out_r;
endmodule

/* fpb_host_ctrl.sv */
// Host controller that runs read, write, program, erase, bypass, autoselect and polling cycles on a parallel flash.
// Assumes one request at a time from the user side and an asynchronous flash on the pins.
`timescale 1ns/100ps

module fpb_host_ctrl #(
  parameter logic [18:0] UNLOCK_ADDR_A   = 19'h00555,
  parameter logic [18:0] UNLOCK_ADDR_B   = 19'h002aa,
  parameter logic [7:0]  CMD_UNLOCK_A    = 8'haa,
  parameter logic [7:0]  CMD_UNLOCK_B    = 8'h55,
  parameter logic [7:0]  CMD_PROGRAM     = 8'ha0,
  parameter logic [7:0]  CMD_BYPASS      = 8'h20,
  parameter logic [7:0]  CMD_BYP_EXIT1   = 8'h90,
  parameter logic [7:0]  CMD_BYP_EXIT2   = 8'h00,
  parameter logic [7:0]  CMD_ERASE_SETUP = 8'h80,
  parameter logic [7:0]  CMD_CHIP_ERASE  = 8'h10,
  parameter logic [7:0]  CMD_SECTOR_ERS  = 8'h30,
  parameter logic [7:0]  CMD_AUTOSELECT  = 8'h90,
  parameter logic [7:0]  CMD_RESET       = 8'hf0
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic                           reqValid,
  output logic                                reqReady,
  input  wire fpb_pkg::fpb_op_t               reqOp,
  input  wire logic [fpb_pkg::ADDR_W-1:0]     reqAddr,
  input  wire logic [fpb_pkg::DATA_W-1:0]     reqData,
  output logic                                rspValid,
  output logic [fpb_pkg::DATA_W-1:0]          rspData,
  output logic                                rspPollBusy,
  output logic                                rspPollMatch,
  output logic                                bypassActive,
  output logic                                flashCeN,
  output logic                                flashOeN,
  output logic                                flashWeN,
  output logic [fpb_pkg::ADDR_W-1:0]          flashAddr,
  output logic [fpb_pkg::DATA_W-1:0]          flashDataOut,
  output logic                                flashDataOe,
  input  wire logic [fpb_pkg::DATA_W-1:0]     flashDataIn
);
  import fpb_pkg::*;

  // ****************************************************************
  // Command sequences
  // ****************************************************************
  function automatic fpb_step_t seqStep(fpb_op_t op, logic [2:0] idx, logic shortPrg,
                                        logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    fpb_step_t         s;
    logic [ADDR_W-1:0] sec;
    s.isRead = 1'b0;
    s.last   = 1'b0;
    s.addr   = (idx == 3'h1 || idx == 3'h4) ? UNLOCK_ADDR_B : UNLOCK_ADDR_A;
    s.data   = (idx == 3'h1 || idx == 3'h4) ? CMD_UNLOCK_B : CMD_UNLOCK_A;
    sec      = {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}}; // see RULE_12
    case (op)
      OP_POLL: begin // see RULE_14
        s.isRead = 1'b1;
        s.addr   = a;
        s.last   = (idx == 3'h1);
      end
      OP_WRITE: begin
        s.addr = a;
        s.data = d;
        s.last = 1'b1;
      end
      OP_RESET: begin
        s.data = CMD_RESET;
        s.last = 1'b1;
      end
      OP_PROGRAM, OP_BYP_PROGRAM: begin
        if (shortPrg) begin // see RULE_10
          s.addr = (idx == 3'h0) ? UNLOCK_ADDR_A : a;
          s.data = (idx == 3'h0) ? CMD_PROGRAM : d;
          s.last = (idx == 3'h1);
        end else if (idx == 3'h2) begin
          s.data = CMD_PROGRAM;
        end else if (idx == 3'h3) begin
          s.addr = a;
          s.data = d;
          s.last = 1'b1;
        end
      end
      OP_BYP_ENTER: begin
        if (idx == 3'h2) begin
          s.data = CMD_BYPASS;
          s.last = 1'b1;
        end
      end
      OP_BYP_EXIT: begin
        s.addr = UNLOCK_ADDR_A;
        s.data = (idx == 3'h0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2;
        s.last = (idx == 3'h1);
      end
      OP_AUTOSELECT: begin
        if (idx == 3'h2) begin
          s.data = CMD_AUTOSELECT;
          s.last = 1'b1;
        end
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin // see RULE_11
        if (idx == 3'h2) begin
          s.data = CMD_ERASE_SETUP;
        end else if (idx == 3'h5) begin
          s.addr = (op == OP_SECTOR_ERASE) ? sec : UNLOCK_ADDR_A;
          s.data = (op == OP_SECTOR_ERASE) ? CMD_SECTOR_ERS : CMD_CHIP_ERASE;
          s.last = 1'b1;
        end
      end
      OP_SECTOR_ADD: begin // see RULE_11
        s.addr = sec;
        s.data = CMD_SECTOR_ERS;
        s.last = 1'b1;
      end
      default: begin
        s.isRead = 1'b1;
        s.addr   = a;
        s.last   = 1'b1;
      end
    endcase
    return s;
  endfunction

  // ****************************************************************
  // Data pin synchroniser
  // ****************************************************************
  fpb_sync_if syncLink ();

  assign syncLink.rawIn = flashDataIn;

  fpb_pin_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .link     (syncLink)
  );

  // ****************************************************************
  // Cycle engine
  // ****************************************************************
  fpb_state_t        state_r,    state_nxt;
  fpb_op_t           op_r,       op_nxt;
  logic [ADDR_W-1:0] addr_r,     addr_nxt;
  logic [DATA_W-1:0] data_r,     data_nxt;
  logic [2:0]        step_r,     step_nxt;
  logic [CNT_W-1:0]  cnt_r,      cnt_nxt;
  logic              short_r,    short_nxt;
  logic              bypass_r,   bypass_nxt;
  logic [DATA_W-1:0] first_r,    first_nxt;
  logic [DATA_W-1:0] rd_r,       rd_nxt;
  logic              ceN_r,      ceN_nxt;
  logic              oeN_r,      oeN_nxt;
  logic              weN_r,      weN_nxt;
  logic              dOe_r,      dOe_nxt;
  logic [ADDR_W-1:0] pinAddr_r,  pinAddr_nxt;
  logic [DATA_W-1:0] pinData_r,  pinData_nxt;
  logic              accept;
  fpb_step_t         cur;
  fpb_step_t         nxt;

  assign reqReady = (state_r == ST_IDLE);
  assign accept   = reqValid && reqReady;
  assign cur      = seqStep(op_r, step_r, short_r, addr_r, data_r);

  always_comb begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    addr_nxt   = addr_r;
    data_nxt   = data_r;
    step_nxt   = step_r;
    cnt_nxt    = cnt_r;
    short_nxt  = short_r;
    bypass_nxt = bypass_r;
    first_nxt  = first_r;
    rd_nxt     = rd_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          op_nxt    = reqOp;
          addr_nxt  = reqAddr;
          data_nxt  = reqData;
          step_nxt  = 3'h0;
          // In bypass mode every program request takes the two-cycle form.
          short_nxt = bypass_r && (reqOp == OP_PROGRAM || reqOp == OP_BYP_PROGRAM); // see RULE_10
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        cnt_nxt   = cur.isRead ? CNT_W'(READ_WAIT_CYC - 1) : CNT_W'(WE_CYC - 1);
        state_nxt = ST_STROBE;
      end
      ST_STROBE: begin
        if (cnt_r == '0) begin
          if (cur.isRead) begin
            if (op_r == OP_POLL && step_r == 3'h0) begin
              first_nxt = syncLink.synced;
            end else begin
              rd_nxt = syncLink.synced;
            end
          end
          state_nxt = ST_RECOVER;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      ST_RECOVER: begin
        if (cur.last) begin
          state_nxt = ST_DONE;
        end else begin
          step_nxt  = step_r + 3'h1;
          state_nxt = ST_SETUP;
        end
      end
      ST_DONE: begin
        if (op_r == OP_BYP_ENTER) begin
          bypass_nxt = 1'b1;
        end else if (op_r == OP_BYP_EXIT) begin
          bypass_nxt = 1'b0;
        end
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Pins follow the next state so that strobes leave flip-flops glitch free.
  assign nxt = seqStep(op_nxt, step_nxt, short_nxt, addr_nxt, data_nxt);

  always_comb begin
    ceN_nxt     = !(state_nxt == ST_SETUP || state_nxt == ST_STROBE);
    oeN_nxt     = !(state_nxt == ST_STROBE && nxt.isRead); // see RULE_01
    weN_nxt     = !(state_nxt == ST_STROBE && !nxt.isRead); // see RULE_03
    // The data bus is driven only around write strobes; output enable is high in all those states.
    dOe_nxt     = !nxt.isRead && (state_nxt == ST_SETUP || state_nxt == ST_STROBE || state_nxt == ST_RECOVER);
    pinAddr_nxt = (state_nxt == ST_IDLE || state_nxt == ST_DONE) ? pinAddr_r : nxt.addr;
    pinData_nxt = (state_nxt == ST_IDLE || state_nxt == ST_DONE) ? pinData_r : nxt.data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      op_r      <= OP_READ;
      addr_r    <= 19'h00000;
      data_r    <= 8'h00;
      step_r    <= 3'h0;
      cnt_r     <= 3'h0;
      short_r   <= 1'b0;
      bypass_r  <= 1'b0;
      first_r   <= 8'h00;
      rd_r      <= 8'h00;
      ceN_r     <= 1'b1;
      oeN_r     <= 1'b1;
      weN_r     <= 1'b1;
      dOe_r     <= 1'b0;
      pinAddr_r <= 19'h00000;
      pinData_r <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      op_r      <= op_nxt;
      addr_r    <= addr_nxt;
      data_r    <= data_nxt;
      step_r    <= step_nxt;
      cnt_r     <= cnt_nxt;
      short_r   <= short_nxt;
      bypass_r  <= bypass_nxt;
      first_r   <= first_nxt;
      rd_r      <= rd_nxt;
      ceN_r     <= ceN_nxt;
      oeN_r     <= oeN_nxt;
      weN_r     <= weN_nxt;
      dOe_r     <= dOe_nxt;
      pinAddr_r <= pinAddr_nxt;
      pinData_r <= pinData_nxt;
    end
  end

  assign rspValid     = (state_r == ST_DONE);
  assign rspData      = rd_r;
  assign rspPollBusy  = first_r[TOGGLE_BIT] ^ rd_r[TOGGLE_BIT]; // see RULE_14
  assign rspPollMatch = (rd_r[POLL_BIT] == data_r[POLL_BIT]); // see RULE_14
  assign bypassActive = bypass_r;
  assign flashCeN     = ceN_r;
  assign flashOeN     = oeN_r;
  assign flashWeN     = weN_r;
  assign flashAddr    = pinAddr_r;
  assign flashDataOut = pinData_r;
  assign flashDataOe  = dOe_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [2:0] weFalls_r;
  logic [2:0] oeFalls_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      weFalls_r <= 3'h0;
      oeFalls_r <= 3'h0;
    end else if (accept) begin
      weFalls_r <= 3'h0;
      oeFalls_r <= 3'h0;
    end else begin
      weFalls_r <= weFalls_r + {2'b00, weN_r && !weN_nxt};
      oeFalls_r <= oeFalls_r + {2'b00, oeN_r && !oeN_nxt};
    end
  end

  sequence sAcceptShort;
    accept && bypass_r && (reqOp == OP_PROGRAM || reqOp == OP_BYP_PROGRAM);
  endsequence

  sequence sAcceptLong;
    accept && !bypass_r && reqOp == OP_PROGRAM;
  endsequence

  chk_read_strobes: assert property (@(posedge core_clk) disable iff (rst) // see RULE_01
    !flashOeN |-> (!flashCeN && flashWeN && !flashDataOe))
    else $error("read strobe without chip select or with write enable low");

  chk_read_hold: assert property (@(posedge core_clk) disable iff (rst) // see RULE_01
    $fell(flashOeN) |-> !flashOeN [*6] ##1 flashOeN)
    else $error("output enable low time is not the read wait");

  chk_write_strobes: assert property (@(posedge core_clk) disable iff (rst) // see RULE_03
    !flashWeN |-> (!flashCeN && flashOeN && flashDataOe))
    else $error("write strobe without chip select, output enable high and data driven");

  chk_bypass_short: assert property (@(posedge core_clk) disable iff (rst) // see RULE_10
    sAcceptShort |-> ##[1:60] (rspValid && weFalls_r == 3'h2))
    else $error("bypass program did not use two write cycles");

  chk_program_long: assert property (@(posedge core_clk) disable iff (rst) // see RULE_10
    sAcceptLong |-> ##[1:60] (rspValid && weFalls_r == 3'h4))
    else $error("standard program did not use four write cycles");

  chk_sector_addr: assert property (@(posedge core_clk) disable iff (rst) // see RULE_12
    (!flashWeN && flashDataOut == CMD_SECTOR_ERS && (op_r == OP_SECTOR_ERASE || op_r == OP_SECTOR_ADD))
      |-> (flashAddr[SECTOR_LSB-1:0] == '0 && flashAddr[ADDR_W-1:SECTOR_LSB] == addr_r[ADDR_W-1:SECTOR_LSB]))
    else $error("sector erase address carries more than the sector bits");

  chk_poll_reads: assert property (@(posedge core_clk) disable iff (rst) // see RULE_14
    (accept && reqOp == OP_POLL) |-> ##[1:40] (rspValid && oeFalls_r == 3'h2 && weFalls_r == 3'h0))
    else $error("status poll did not make two reads");

  chk_idle_pins: assert property (@(posedge core_clk) disable iff (rst) // see RULE_03
    reqReady |-> (flashCeN && flashOeN && flashWeN))
    else $error("strobes active while idle");
endmodule

/* fpb_flash_model.sv */
// Behavioural byte-wide parallel flash that answers the host controller in the bench.
// Assumes the bench resolves the shared data bus from the host drive enable alone.
`timescale 1ns/100ps

module fpb_flash_model #(
  parameter logic [7:0] MFR_ID     = 8'h3c, // Arbitrary value.
  parameter logic [7:0] DEV_ID     = 8'hc3, // Arbitrary value.
  parameter int         BUSY_READS = 4
) (
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  hostData,
  input  wire logic        hostDrive,
  output logic      [7:0]  q
);
  // ********
  // Array and command state
  // ********
  logic [7:0] mem [logic [18:0]];
  logic [7:0] erasedSec  = 8'h00;
  logic [7:0] rd         = 8'h00;
  logic [7:0] lastQ      = 8'h00;
  logic [7:0] lastProg   = 8'h00;
  logic [3:0] stage      = 4'h0;
  logic       autoSel    = 1'b0;
  logic       bypass     = 1'b0;
  logic       tog        = 1'b0;
  logic       armed      = 1'b0;
  int         busyLeft   = 0;
  int         violations = 0;

  function automatic logic [7:0] arr(input logic [18:0] a);
    if (mem.exists(a)) return mem[a];
    if (erasedSec[a[18:16]]) return 8'hff;
    return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
  endfunction

  // Released pins show the inverse of the last byte, so a stale capture cannot pass.
  assign #60 q = (!ceN && !oeN) ? rd : ~lastQ;

  always @(negedge oeN) begin
    if ((!ceN && hostDrive) || !weN) violations++;
    if (busyLeft > 0) tog = ~tog;
    rd = autoSel ? (addr[0] ? DEV_ID : MFR_ID) :
         (busyLeft > 0) ? {~lastProg[7], tog, 6'h00} : arr(addr);
  end

  always @(posedge oeN) begin
    lastQ = rd;
    if (busyLeft > 0) busyLeft--;
  end

  always @(negedge weN) begin
    armed = !ceN && oeN;
    if (!oeN) violations++;
  end

  always @(posedge weN) begin
    if (armed && !hostDrive) violations++;
    if (armed) take(addr, hostData);
    armed = 1'b0;
  end

  task automatic take(input logic [18:0] a, input logic [7:0] d);
    logic cmd;
    cmd = (a == 19'h00555);
    case (stage)
      4'h0: if (d == 8'hf0) autoSel = 1'b0;
            else if (bypass) stage = (d == 8'ha0) ? 4'h3 : (d == 8'h90) ? 4'h8 : 4'h0;
            else stage = (cmd && d == 8'haa) ? 4'h1 : 4'h0;
      4'h1, 4'h5: stage = (a == 19'h002aa && d == 8'h55) ? stage + 4'h1 : 4'h0;
      4'h4: stage = (cmd && d == 8'haa) ? 4'h5 : 4'h0;
      4'h2: begin
        stage = (cmd && d == 8'ha0) ? 4'h3 : (cmd && d == 8'h80) ? 4'h4 : 4'h0;
        if (cmd && d == 8'h20) bypass = 1'b1;
        if (cmd && d == 8'h90) autoSel = 1'b1;
      end
      4'h3: begin
        mem[a] = arr(a) & d;
        lastProg = d;
        busyLeft = BUSY_READS;
        stage = 4'h0;
      end
      4'h6, 4'h7: begin
        if (stage == 4'h6 && d == 8'h10) begin
          erasedSec = 8'hff;
          mem.delete();
        end
        if (d == 8'h30) erasedSec[a[18:16]] = 1'b1;
        lastProg = 8'hff;
        if (d == 8'h10 || d == 8'h30) busyLeft = BUSY_READS + 2;
        stage = (d == 8'h30) ? 4'h7 : (stage == 4'h7 && cmd && d == 8'haa) ? 4'h1 : 4'h0;
      end
      4'h8: begin
        if (d == 8'h00) bypass = 1'b0;
        stage = 4'h0;
      end
      default: stage = 4'h0;
    endcase
  endtask
endmodule

/* fpb_host_ctrl_bench.sv */
// Self-checking bench for the flash host controller against the behavioural flash.
// Assumes the package, the controller and the flash model are compiled first.
`timescale 1ns/100ps

module fpb_host_ctrl_bench;
  import fpb_pkg::*;
  // ********
  // Signals
  // ********
  localparam logic [7:0] MFR = 8'h3c; // Arbitrary value.
  localparam logic [7:0] DEV = 8'hc3; // Arbitrary value.
  typedef struct packed {
    logic       chk;
    logic [7:0] data;
  } fpb_note_t;
  logic              core_clk = 1'b0;
  logic              rst      = 1'b1;
  logic              reqValid = 1'b0;
  fpb_op_t           reqOp    = OP_READ;
  logic [ADDR_W-1:0] reqAddr  = 19'h00000;
  logic [DATA_W-1:0] reqData  = 8'h00;
  logic              reqReady, rspValid, rspPollBusy, rspPollMatch, bypassActive;
  logic              flashCeN, flashOeN, flashWeN, flashDataOe;
  logic [ADDR_W-1:0] flashAddr;
  logic [DATA_W-1:0] rspData, flashDataOut, flashDataIn, modelQ;
  fpb_note_t         notes[$];
  fpb_note_t         nt;
  int                errTotal   = 0;
  int                checkCount = 0;
  int                weFalls    = 0;
  logic [31:0]       rnd        = 32'h6d9f;

  initial forever #50 core_clk = ~core_clk;
  assign flashDataIn = flashDataOe ? flashDataOut : modelQ;
  always @(negedge flashWeN) weFalls++;

  fpb_host_ctrl dut (.core_clk(core_clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
    .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
    .rspPollBusy(rspPollBusy), .rspPollMatch(rspPollMatch), .bypassActive(bypassActive),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .flashAddr(flashAddr),
    .flashDataOut(flashDataOut), .flashDataOe(flashDataOe), .flashDataIn(flashDataIn));

  fpb_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .BUSY_READS(4)) flash (.ceN(flashCeN),
    .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr), .hostData(flashDataOut),
    .hostDrive(flashDataOe), .q(modelQ));

  // ********
  // Helpers
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tallyAndFinish;
    $display("checks=%0d mismatches=%0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic giveUp;
    check(32'h0, 32'h1);
    tallyAndFinish();
  endtask

  function automatic logic [7:0] patt(input logic [18:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
  endfunction

  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic roll(output logic [18:0] a, output logic [7:0] d);
    rnd = lfsrNext(rnd);
    a = rnd[18:0];
    rnd = lfsrNext(rnd);
    d = rnd[7:0];
  endtask

  // The request is held from just after one edge until the edge that takes it.
  task automatic runOp(input fpb_op_t o, input logic [18:0] a, input logic [7:0] d,
                       input logic chk, input logic [7:0] ex, input int pulses);
    int n;
    n = 0;
    while (reqReady !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 40) giveUp();
    end
    reqValid = 1'b1;
    reqOp = o;
    reqAddr = a;
    reqData = d;
    weFalls = 0;
    notes.push_back('{chk, ex});
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
    n = 1;
    while (rspValid !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 40) giveUp();
    end
    check(weFalls, pulses);
    check(n, (pulses > 0) ? 3 * pulses + 1 : (o == OP_POLL) ? 17 : 9);
  endtask

  task automatic pollDone(input logic [18:0] a, input logic [7:0] d, input int busyPolls);
    int k;
    k = 0;
    runOp(OP_POLL, a, d, 1'b0, 8'h00, 0);
    while (rspPollBusy !== 1'b0) begin
      k++;
      if (k > 8) giveUp();
      runOp(OP_POLL, a, d, 1'b0, 8'h00, 0);
    end
    check(k, busyPolls);
    check(rspPollMatch, 1'b1);
  endtask

  always @(posedge core_clk) begin
    if (rspValid === 1'b1) begin
      if (notes.size() == 0) giveUp();
      nt = notes.pop_front();
      if (nt.chk) check(rspData, nt.data);
    end
  end

  // ********
  // Scenarios
  // ********
  initial begin
    logic [18:0] a;
    logic [7:0]  d;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check({flashCeN, flashOeN, flashWeN, flashDataOe, bypassActive, reqReady}, 6'h39);
    $display("test reset done");
    repeat (4) begin
      roll(a, d);
      runOp(OP_READ, a, 8'h00, 1'b1, patt(a), 0);
    end
    runOp(fpb_op_t'(4'hf), a, 8'h00, 1'b1, patt(a), 0);
    runOp(OP_WRITE, a, 8'h00, 1'b0, 8'h00, 1);
    runOp(OP_READ, a, 8'h00, 1'b1, patt(a), 0);
    $display("test array read done");
    runOp(OP_AUTOSELECT, 19'h00000, 8'h00, 1'b0, 8'h00, 3);
    runOp(OP_READ, 19'h00000, 8'h00, 1'b1, MFR, 0);
    runOp(OP_READ, 19'h00001, 8'h00, 1'b1, DEV, 0);
    runOp(OP_RESET, 19'h00000, 8'h00, 1'b0, 8'h00, 1);
    runOp(OP_READ, 19'h00001, 8'h00, 1'b1, patt(19'h00001), 0);
    $display("test autoselect done");
    runOp(OP_SECTOR_ERASE, 19'h2abcd, 8'h00, 1'b0, 8'h00, 6);
    runOp(OP_SECTOR_ADD, 19'h5f00f, 8'h00, 1'b0, 8'h00, 1);
    pollDone(19'h20000, 8'hff, 3);
    for (int s = 0; s < 8; s++) begin
      roll(a, d);
      a[18:16] = s[2:0];
      runOp(OP_READ, a, 8'h00, 1'b1, (s == 2 || s == 5) ? 8'hff : patt(a), 0);
    end
    runOp(OP_CHIP_ERASE, 19'h00000, 8'h00, 1'b0, 8'h00, 6);
    pollDone(19'h00000, 8'hff, 3);
    roll(a, d);
    runOp(OP_READ, a, 8'h00, 1'b1, 8'hff, 0);
    $display("test erase done");
    for (int i = 0; i < 5; i++) begin
      if (i == 1) runOp(OP_BYP_ENTER, 19'h00000, 8'h00, 1'b0, 8'h00, 3);
      if (i == 4) runOp(OP_BYP_EXIT, 19'h00000, 8'h00, 1'b0, 8'h00, 2);
      // The mode flag turns over only at the edge that leaves the done state.
      @(posedge core_clk);
      #1;
      check(bypassActive, (i == 0 || i == 4) ? 1'b0 : 1'b1);
      roll(a, d);
      runOp((i == 2) ? OP_BYP_PROGRAM : OP_PROGRAM, a, d, 1'b0, 8'h00, (i == 0 || i == 4) ? 4 : 2);
      pollDone(a, d, 2);
      runOp(OP_READ, a, 8'h00, 1'b1, d, 0);
    end
    // The monitor takes the last note at the edge that closes its response, so let that edge pass.
    @(posedge core_clk);
    #1;
    check(notes.size(), 0);
    $display("test program done");
    check(flash.violations, 0);
    tallyAndFinish();
  end
endmodule
